// *** logic/imc_defines.svh ***
`ifndef IMC_DEFINES_SVH
`define IMC_DEFINES_SVH

// Data path widths and transmit buffer depth.
`define IMC_DATA_W 8
`define IMC_FIFO_DEPTH 8
// Baud generator width and its reset value.
`define IMC_BRG_W 16
`define IMC_BRG_RST 16'h0000
// Each bit on the bus is cut into four baud ticks.
`define IMC_PH_LAST 2'h3
`define IMC_BIT_FIRST 3'h7
// First byte pattern that marks a 10-bit address.
`define IMC_TENBIT_PFX 5'h1E

`endif

// *** logic/imc_pkg.sv ***
package imc_pkg;

  typedef enum logic [2:0] {
    IMC_IDLE = 3'b000,
    IMC_START = 3'b001,
    IMC_BYTE = 3'b010,
    IMC_ACK = 3'b011,
    IMC_STOP = 3'b100,
    IMC_HALT = 3'b101
  } imc_state_e;

  typedef struct packed {
    logic controllerOn;
    logic txIrqEnable;
    logic baudTimerIrqEnable;
    logic nakRequest;
  } imc_ctrl_s;

  typedef struct packed {
    logic txHoldingEmpty;
    logic rxHoldingFull;
    logic nackIrqFlag;
    logic ackStatus;
    logic startPending;
    logic stopPending;
    logic readMode;
    logic busy;
  } imc_status_s;

endpackage

// *** logic/imc_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
module imc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic flush,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // Drain side; data appear in outData one cycle after the pop
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign inReady = (count_reg != D[AW:0]);
  assign outValid = (count_reg != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || flush) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= AW'(wrPtr_reg + 1'b1);
      end
      if (pop) begin
        rdPtr_reg <= AW'(rdPtr_reg + 1'b1);
      end
      count_reg <= (AW + 1)'(count_reg + push - pop);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      outData <= '0;
    end else if (pop) begin
      outData <= mem[rdPtr_reg];
    end
  end

endmodule // imc_fifo
`default_nettype wire

// *** logic/imc_master.sv ***
// How it works
// - Transmit interrupt needs empty flag and enable.
// - Empty flag sets on enable and first bits.
// - Data write clears the empty flag.
// - Stall at acknowledge while nothing to send.
// - Disabled controller uses baud generator as timer.
// - Empty flag visible regardless of interrupt enable.
// - DMA requests only with transmit interrupt enabled.
// - Early not-acknowledge flags and halts until request.
// - Low SDA in acknowledge sets ack status.
// - Not-acknowledge sets flag, clears ack status.
// - Stop after not-acknowledge clears stop, flag.
// - Transmit interrupt at start of first data bit.
// - Pending request suppresses last-byte not-acknowledge.
// - Finish with stop or restart, clear request.
// - Read byte answers not-acknowledge on refusal request or pending stop/start.
// - Status exposes empty, full and not-acknowledge.
`timescale 1ns/100ps
`default_nettype none
`include "imc_defines.svh"
module imc_master (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Software control
  input wire imc_pkg::imc_ctrl_s ctrl,
  input wire logic [`IMC_BRG_W-1:0] baudDivisor,
  input wire logic startSet,
  input wire logic stopSet,
  input wire logic flushSet,
  // Transmit data
  input wire logic dataWrite,
  input wire logic [`IMC_DATA_W-1:0] dataIn,
  output logic dataWrReady,
  // Receive data
  input wire logic rxRead,
  output logic [`IMC_DATA_W-1:0] rxData,
  // Status and requests
  output imc_pkg::imc_status_s status,
  output logic irq,
  output logic dmaTxReq,
  // Bus pins, open drain
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);

  ////////////////////////////////////////////////////////////////////////////
  imc_pkg::imc_state_e state_reg;
  logic [1:0] phase_reg;
  logic [2:0] bitCnt_reg;
  logic [`IMC_DATA_W-1:0] shift_reg;
  logic addrByte_reg;
  logic readMode_reg;
  logic loadPend_reg;
  logic sclOe_reg;
  logic sdaOe_reg;
  logic [`IMC_BRG_W-1:0] brgCnt_reg;
  logic baudIrq_reg;
  logic onPrev_reg;
  logic txEmpty_reg;
  logic rxFull_reg;
  logic nack_reg;
  logic ack_reg;
  logic startReq_reg;
  logic stopReq_reg;
  logic [2:0] sclSync_reg;
  logic [2:0] sdaSync_reg;
  logic sclF_reg;
  logic sdaF_reg;
  logic fifoValid;
  logic fifoPop;
  logic [`IMC_DATA_W-1:0] fifoData;
  logic tick;
  logic reqPending;
  logic rxByte;
  logic stall;
  logic firstBit;
  logic txEmptySet;
  logic ackSample;
  logic nackEvent;
  logic rxDone;
  logic startDone;
  logic stopDone;

  // A change on a pin counts once the last two stages agree.
  function automatic logic filt(input logic [2:0] s, input logic prev);
    return (s[1] == s[2]) ? s[2] : prev;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  imc_fifo #(
    .W(`IMC_DATA_W),
    .D(`IMC_FIFO_DEPTH)
  ) u_txFifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .flush(flushSet),
    .inValid(dataWrite),
    .inReady(dataWrReady),
    .inData(dataIn),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sclSync_reg <= 3'h7;
      sdaSync_reg <= 3'h7;
      sclF_reg <= 1'b1;
      sdaF_reg <= 1'b1;
    end else begin
      sclSync_reg <= {sclSync_reg[1:0], sclIn};
      sdaSync_reg <= {sdaSync_reg[1:0], sdaIn};
      sclF_reg <= filt(sclSync_reg, sclF_reg);
      sdaF_reg <= filt(sdaSync_reg, sdaF_reg);
    end
  end

  // The generator reloads after reaching one, so it also serves as a
  // plain interval timer while the controller is switched off.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      brgCnt_reg <= `IMC_BRG_RST;
      baudIrq_reg <= 1'b0;
    end else begin
      if (brgCnt_reg <= `IMC_BRG_W'(1)) begin
        brgCnt_reg <= baudDivisor;
      end else begin
        brgCnt_reg <= `IMC_BRG_W'(brgCnt_reg - 1'b1);
      end
      baudIrq_reg <= !ctrl.controllerOn && ctrl.baudTimerIrqEnable &&
        (brgCnt_reg == `IMC_BRG_W'(1));
    end
  end

  assign tick = ctrl.controllerOn && (brgCnt_reg == `IMC_BRG_W'(1));

  ////////////////////////////////////////////////////////////////////////////
  assign reqPending = startReq_reg || stopReq_reg;
  assign rxByte = readMode_reg && !addrByte_reg;
  // A read address byte needs no next transmit byte, so it never stalls.
  assign stall = state_reg == imc_pkg::IMC_ACK && phase_reg == 2'h0 &&
    !rxByte && !(addrByte_reg && readMode_reg) && !fifoValid &&
    !reqPending;
  assign firstBit = tick && state_reg == imc_pkg::IMC_BYTE &&
    phase_reg == 2'h0 && bitCnt_reg == `IMC_BIT_FIRST && !rxByte;
  assign txEmptySet = !fifoValid && ((ctrl.controllerOn && !onPrev_reg) ||
    (firstBit && (!addrByte_reg || !shift_reg[0] ||
    shift_reg[7:3] == `IMC_TENBIT_PFX)));
  assign ackSample = tick && state_reg == imc_pkg::IMC_ACK &&
    phase_reg == 2'h2 && !rxByte;
  assign nackEvent = ackSample && sdaF_reg && !reqPending;
  assign rxDone = tick && state_reg == imc_pkg::IMC_BYTE && rxByte &&
    phase_reg == `IMC_PH_LAST && bitCnt_reg == 3'h0;
  assign startDone = tick && state_reg == imc_pkg::IMC_START &&
    phase_reg == `IMC_PH_LAST && fifoValid;
  assign stopDone = tick && state_reg == imc_pkg::IMC_STOP &&
    phase_reg == `IMC_PH_LAST;
  // A refused byte leaves the next one buffered, so a halt loses nothing.
  assign fifoPop = startDone || (tick && state_reg == imc_pkg::IMC_ACK &&
    phase_reg == `IMC_PH_LAST && !reqPending && !sdaF_reg && !rxByte &&
    !(addrByte_reg && readMode_reg) && fifoValid);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= imc_pkg::IMC_IDLE;
      phase_reg <= 2'h0;
      bitCnt_reg <= `IMC_BIT_FIRST;
      shift_reg <= '0;
      addrByte_reg <= 1'b0;
      readMode_reg <= 1'b0;
      loadPend_reg <= 1'b0;
      sclOe_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
      rxData <= '0;
    end else if (!ctrl.controllerOn) begin
      state_reg <= imc_pkg::IMC_IDLE;
      phase_reg <= 2'h0;
      sclOe_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
      loadPend_reg <= 1'b0;
    end else begin
      loadPend_reg <= fifoPop;
      if (loadPend_reg) begin
        shift_reg <= fifoData;
      end
      if (tick && !stall) begin
        phase_reg <= 2'(phase_reg + 1'b1);
        case (state_reg)
          imc_pkg::IMC_IDLE: begin
            phase_reg <= 2'h0;
            if (startReq_reg && fifoValid) begin
              state_reg <= imc_pkg::IMC_START;
            end
          end
          imc_pkg::IMC_START: begin
            case (phase_reg)
              2'h0: begin
                sdaOe_reg <= 1'b0;
                sclOe_reg <= 1'b0;
              end
              2'h1: sdaOe_reg <= 1'b1;
              2'h2: sclOe_reg <= 1'b1;
              default: begin
                // Holds here until the address byte is in the buffer.
                if (!fifoValid) begin
                  phase_reg <= phase_reg;
                end else begin
                  state_reg <= imc_pkg::IMC_BYTE;
                  bitCnt_reg <= `IMC_BIT_FIRST;
                  addrByte_reg <= 1'b1;
                end
              end
            endcase
          end
          imc_pkg::IMC_BYTE: begin
            case (phase_reg)
              2'h0: sdaOe_reg <= !rxByte && !shift_reg[bitCnt_reg];
              2'h1: sclOe_reg <= 1'b0;
              2'h2: begin
                if (rxByte) begin
                  shift_reg[bitCnt_reg] <= sdaF_reg;
                end
              end
              default: begin
                sclOe_reg <= 1'b1;
                bitCnt_reg <= 3'(bitCnt_reg - 1'b1);
                if (bitCnt_reg == 3'h0) begin
                  state_reg <= imc_pkg::IMC_ACK;
                  if (addrByte_reg) begin
                    readMode_reg <= shift_reg[0];
                  end
                  if (rxByte) begin
                    rxData <= shift_reg;
                  end
                end
              end
            endcase
          end
          imc_pkg::IMC_ACK: begin
            case (phase_reg)
              // A read answers low unless this byte is to be the last.
              2'h0: sdaOe_reg <= rxByte && !ctrl.nakRequest &&
                !reqPending;
              2'h1: sclOe_reg <= 1'b0;
              2'h2: ;
              default: begin
                sclOe_reg <= 1'b1;
                sdaOe_reg <= 1'b0;
                bitCnt_reg <= `IMC_BIT_FIRST;
                if (addrByte_reg && readMode_reg) begin
                  addrByte_reg <= 1'b0;
                end
                if (sdaF_reg && !rxByte && !reqPending) begin
                  state_reg <= imc_pkg::IMC_HALT;
                end else if (stopReq_reg) begin
                  state_reg <= imc_pkg::IMC_STOP;
                end else if (startReq_reg) begin
                  state_reg <= imc_pkg::IMC_START;
                end else begin
                  state_reg <= imc_pkg::IMC_BYTE;
                  if (fifoPop) begin
                    addrByte_reg <= 1'b0;
                  end
                end
              end
            endcase
          end
          imc_pkg::IMC_STOP: begin
            case (phase_reg)
              2'h0: begin
                sclOe_reg <= 1'b1;
                sdaOe_reg <= 1'b1;
              end
              2'h1: sclOe_reg <= 1'b0;
              2'h2: sdaOe_reg <= 1'b0;
              default: begin
                state_reg <= imc_pkg::IMC_IDLE;
                readMode_reg <= 1'b0;
              end
            endcase
          end
          imc_pkg::IMC_HALT: begin
            phase_reg <= 2'h0;
            if (stopReq_reg) begin
              state_reg <= imc_pkg::IMC_STOP;
            end else if (startReq_reg) begin
              state_reg <= imc_pkg::IMC_START;
            end
          end
          default: state_reg <= imc_pkg::IMC_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hardware sets win over the clear in the same cycle.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      onPrev_reg <= 1'b0;
      txEmpty_reg <= 1'b0;
    end else begin
      onPrev_reg <= ctrl.controllerOn;
      if (txEmptySet || flushSet) begin
        txEmpty_reg <= 1'b1;
      end else if (dataWrite) begin
        txEmpty_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      nack_reg <= 1'b0;
      ack_reg <= 1'b0;
      rxFull_reg <= 1'b0;
    end else begin
      if (nackEvent) begin
        nack_reg <= 1'b1;
      end else if (stopDone) begin
        nack_reg <= 1'b0;
      end
      if (ackSample) begin
        ack_reg <= !sdaF_reg;
      end
      if (rxDone) begin
        rxFull_reg <= 1'b1;
      end else if (rxRead) begin
        rxFull_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      startReq_reg <= 1'b0;
      stopReq_reg <= 1'b0;
    end else begin
      if (startSet) begin
        startReq_reg <= 1'b1;
      end else if (startDone) begin
        startReq_reg <= 1'b0;
      end
      if (stopSet) begin
        stopReq_reg <= 1'b1;
      end else if (stopDone) begin
        stopReq_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign status = '{
    txHoldingEmpty: txEmpty_reg,
    rxHoldingFull: rxFull_reg,
    nackIrqFlag: nack_reg,
    ackStatus: ack_reg,
    startPending: startReq_reg,
    stopPending: stopReq_reg,
    readMode: readMode_reg,
    busy: state_reg != imc_pkg::IMC_IDLE
  };
  assign irq = (txEmpty_reg && ctrl.txIrqEnable) || nack_reg ||
    rxFull_reg || baudIrq_reg;
  assign dmaTxReq = txEmpty_reg && ctrl.txIrqEnable && dataWrReady;
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = sclOe_reg;
  assign sdaOe = sdaOe_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_write_clears: assert property (
    dataWrite && !txEmptySet && !flushSet |=> !status.txHoldingEmpty)
    else $error("data write left the empty flag set");
  a_flush_empty: assert property (
    flushSet |=> status.txHoldingEmpty && !fifoValid)
    else $error("flush left data pending");
  a_stall_hold: assert property (
    stall && ctrl.controllerOn |=> state_reg == imc_pkg::IMC_ACK &&
    phase_reg == 2'h0)
    else $error("controller moved on during stall");
  a_nack_halt: assert property (
    nackEvent && ctrl.controllerOn |=> status.nackIrqFlag ##[0:300]
    (state_reg == imc_pkg::IMC_HALT || reqPending || !ctrl.controllerOn))
    else $error("not-acknowledge did not halt");
  a_baud_timer: assert property (
    !ctrl.controllerOn && ctrl.baudTimerIrqEnable &&
    brgCnt_reg == `IMC_BRG_W'(1) |=> irq)
    else $error("baud timer interrupt missing");
  a_dma_gate: assert property (
    dmaTxReq |-> ctrl.txIrqEnable && status.txHoldingEmpty)
    else $error("DMA request without enable");
  a_stop_clears: assert property (
    stopDone && !stopSet |=> !status.stopPending && !status.nackIrqFlag)
    else $error("stop did not clear request and flag");
  a_ack_status: assert property (
    ackSample |=> status.ackStatus == !$past(sdaF_reg))
    else $error("ack status wrong after sample");
  a_last_no_nack: assert property (
    ackSample && reqPending && !status.nackIrqFlag |=>
    !status.nackIrqFlag)
    else $error("not-acknowledge flagged despite request");
  a_reset_idle: assert property (
    disable iff (1'b0) !rst_n |=> !sclOe && !sdaOe &&
    !status.stopPending && !status.startPending)
    else $error("reset did not release the bus");
  a_scl_release: assert property (
    $fell(sclOe) |-> ##4 sclF_reg)
    else $error("clock line did not rise after release");

endmodule // imc_master
`default_nettype wire

// *** dv/imc_slave_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module imc_slave_model (
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Behaviour asked by the bench
  input wire logic nackData,
  input wire logic [7:0] rdByte,
  // Responses
  output logic sdaPull,
  output logic [63:0] gotBytes,
  output logic lastAck
);
  int cnt;
  logic act;
  logic first;
  logic rd;
  logic [7:0] shreg;

  initial begin
    sdaPull = 1'b0;
    gotBytes = '0;
    lastAck = 1'b0;
    act = 1'b0;
    cnt = 0;
    first = 1'b0;
    rd = 1'b0;
    shreg = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // The START edge itself pulls SCL low once, so counting begins at -1.
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    first = 1'b1;
    rd = 1'b0;
    cnt = -1;
    sdaPull = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    act = 1'b0;
    sdaPull = 1'b0;
  end
  always @(posedge scl) if (act) begin
    if (cnt < 8) shreg = {shreg[6:0], sda};
    else lastAck = sda;
  end
  always @(negedge scl) if (act) begin
    cnt = cnt + 1;
    if (cnt == 8) begin
      if (first || !rd) gotBytes = {gotBytes[55:0], shreg};
      sdaPull = (first || !rd) && !(nackData && !first);
    end else if (cnt == 9) begin
      cnt = 0;
      // A master that refused a read byte ends the read, so let go.
      if (!first && rd && lastAck) act = 1'b0;
      if (first) rd = shreg[0];
      first = 1'b0;
      sdaPull = act && rd && !rdByte[7];
    end else begin
      sdaPull = rd && !first && cnt > 0 && !rdByte[7-cnt];
    end
  end
endmodule // imc_slave_model
`default_nettype wire

// *** dv/imc_master_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "imc_defines.svh"
module imc_master_bench;
  logic mclk;
  logic rst_n;
  imc_pkg::imc_ctrl_s ctrl;
  imc_pkg::imc_status_s status;
  logic [15:0] baudDivisor;
  logic startSet, stopSet, flushSet, dataWrite, rxRead;
  logic dataWrReady, irq, dmaTxReq, sclOut, sclOe, sdaOut, sdaOe;
  logic [7:0] dataIn, rxData, rdByte;
  logic sclW, sdaW, slvPull, nackData, lastAck;
  logic [63:0] gotBytes, expBytes;
  logic [31:0] rnd;
  int nFail, totalChecks, nb, t;

  // Pull-ups on both lines; anyone driving wins low.
  assign sclW = sclOe ? sclOut : 1'b1;
  assign sdaW = (sdaOe ? sdaOut : 1'b1) & ~slvPull;

  imc_master uut (.mclk(mclk), .rst_n(rst_n), .ctrl(ctrl),
    .baudDivisor(baudDivisor), .startSet(startSet), .stopSet(stopSet),
    .flushSet(flushSet), .dataWrite(dataWrite), .dataIn(dataIn),
    .dataWrReady(dataWrReady), .rxRead(rxRead), .rxData(rxData),
    .status(status), .irq(irq), .dmaTxReq(dmaTxReq), .sclIn(sclW),
    .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(sdaOut),
    .sdaOe(sdaOe));
  imc_slave_model slave (.scl(sclW), .sda(sdaW), .nackData(nackData),
    .rdByte(rdByte), .sdaPull(slvPull), .gotBytes(gotBytes),
    .lastAck(lastAck));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic pick(input int i);
    case (i)
      0: return status.busy;
      1: return status.txHoldingEmpty;
      2: return status.nackIrqFlag;
      3: return status.rxHoldingFull;
      default: return irq;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [63:0] ex,
                     input logic [63:0] got);
    totalChecks++;
    if (got !== ex) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Status is sampled on falling edges, after the rising edge has landed.
  task automatic waitFor(input int i, input logic v, input string nm);
    int n;
    n = 0;
    @(negedge mclk);
    while (pick(i) !== v && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    if (pick(i) !== v) begin
      nFail++;
      $display("mismatch %s expected %b seen %b", nm, v, pick(i));
      giveVerdict();
    end
  endtask

  task automatic push(input logic [7:0] b);
    @(posedge mclk);
    dataIn <= b;
    dataWrite <= 1'b1;
    @(posedge mclk);
    dataWrite <= 1'b0;
  endtask

  // Bits of m: start, stop, flush, receive-read.
  task automatic pulse(input logic [3:0] m);
    @(posedge mclk);
    {startSet, stopSet, flushSet, rxRead} <= m;
    if (m[2]) ctrl.txIrqEnable <= 1'b0;
    @(posedge mclk);
    {startSet, stopSet, flushSet, rxRead} <= 4'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ctrl = '0;
    baudDivisor = 16'h0004;
    {startSet, stopSet, flushSet, rxRead, dataWrite} = 5'h00;
    dataIn = 8'h00;
    rdByte = 8'h00;
    nackData = 1'b0;
    rnd = 32'hEFB1;
    nFail = 0;
    totalChecks = 0;
    expBytes = '0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk("status", 64'h0, status);
    chk("pinEnables", 64'h0, {sclOe, sdaOe});
    @(posedge mclk);
    ctrl.controllerOn <= 1'b1;
    waitFor(1, 1'b1, "emptyOnEnable");
    chk("irqMasked", 64'h0, irq);
    @(posedge mclk);
    ctrl.txIrqEnable <= 1'b1;
    @(negedge mclk);
    chk("txIrq", 64'h1, irq);
    chk("dmaReq", 64'h1, dmaTxReq);
    @(posedge mclk);
    ctrl.txIrqEnable <= 1'b0;
    @(negedge mclk);
    chk("dmaOff", 64'h0, dmaTxReq);
    $display("test enable done");
    for (int i = 0; i <= `IMC_FIFO_DEPTH; i++) push(8'hA5);
    @(negedge mclk);
    chk("fullReady", 64'h0, dataWrReady);
    chk("emptyAfterWrite", 64'h0, status.txHoldingEmpty);
    pulse(4'h2);
    waitFor(1, 1'b1, "emptyAfterFlush");
    chk("readyAfterFlush", 64'h1, dataWrReady);
    $display("test fill done");
    // Second pass refuses its only data byte while the stop is pending.
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      nb = (k == 1) ? 1 : 2 + int'(rnd[9:8]);
      nackData = k[0];
      expBytes = {56'h0, rnd[7:1], 1'b0};
      push(expBytes[7:0]);
      for (int j = 0; j < nb; j++) begin
        rnd = lfsr(rnd);
        expBytes = {expBytes[55:0], rnd[7:0]};
        push(rnd[7:0]);
      end
      @(posedge mclk);
      ctrl.txIrqEnable <= 1'b1;
      pulse(4'h8);
      waitFor(1, 1'b1, "emptyLastByte");
      chk("txIrqLast", 64'h1, irq);
      if (k == 0) begin
        repeat (300) @(negedge mclk);
        chk("stallBusy", 64'h1, status.busy);
        chk("stallScl", 64'h1, sclOe);
      end
      pulse(4'h4);
      waitFor(0, 1'b0, "stopDone");
      chk("bytes", expBytes, gotBytes & ((64'h1 << (8*nb+8)) - 64'h1));
      chk("nackFlag", 64'h0, status.nackIrqFlag);
      chk("stopClear", 64'h0, status.stopPending);
      chk("pinsFree", 64'h0, {sclOe, sdaOe});
      if (k == 0) chk("ack", 64'h1, status.ackStatus);
    end
    $display("test write done");
    nackData = 1'b1;
    push(8'h54);
    push(rnd[7:0]);
    push(rnd[15:8]);
    pulse(4'h8);
    waitFor(2, 1'b1, "nackSet");
    chk("ackCleared", 64'h0, status.ackStatus);
    chk("nackIrq", 64'h1, irq);
    repeat (200) @(negedge mclk);
    chk("halted", 64'h1, status.busy);
    pulse(4'h6);
    waitFor(0, 1'b0, "stopAfterNack");
    chk("nackCleared", 64'h0, status.nackIrqFlag);
    chk("stopCleared", 64'h0, status.stopPending);
    chk("flushed", 64'h1, status.txHoldingEmpty);
    $display("test nack done");
    rnd = lfsr(rnd);
    nackData = 1'b0;
    rdByte = rnd[15:8];
    @(posedge mclk);
    ctrl.nakRequest <= 1'b1;
    push({rnd[7:1], 1'b1});
    pulse(4'h8);
    waitFor(3, 1'b1, "rxFull");
    chk("rxData", {56'h0, rnd[15:8]}, rxData);
    // Let the answer slot open first, so only the refusal request can
    // make the master leave the data line high there.
    repeat (6) @(negedge mclk);
    pulse(4'h4);
    waitFor(0, 1'b0, "readDone");
    chk("masterNack", 64'h1, lastAck);
    pulse(4'h1);
    @(negedge mclk);
    chk("rxCleared", 64'h0, status.rxHoldingFull);
    $display("test read done");
    rnd = lfsr(rnd);
    @(posedge mclk);
    ctrl <= '{1'b0, 1'b0, 1'b1, 1'b0};
    baudDivisor <= {12'h000, rnd[3:0]} + 16'h0005;
    waitFor(4, 1'b1, "timerIrq");
    // The first interval may still run on the old reload value.
    for (int r = 0; r < 2; r++) begin
      t = 0;
      do begin
        @(negedge mclk);
        t++;
      end while (irq !== 1'b1 && t < 100);
    end
    chk("timerPeriod", {48'h0, baudDivisor}, t);
    $display("test timer done");
    giveVerdict();
  end
endmodule // imc_master_bench
`default_nettype wire
